//--- design/dcc_pkg.sv
// Purpose: Shared constants and types for the DMA CRC and channel control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Offsets are byte addresses
package dcc_pkg;
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  OFS_SETUP   = 8'h00;
  localparam logic [7:0]  OFS_SEED    = 8'h04;
  localparam logic [7:0]  OFS_TAPS    = 8'h08;
  localparam logic [7:0]  OFS_CTRL    = 8'h0c;
  localparam logic [7:0]  OFS_ISTAT   = 8'h10;
  localparam logic [7:0]  OFS_ICLR    = 8'h14;
  localparam logic [7:0]  OFS_IEN     = 8'h18;
  localparam int          CC_BUSY     = 15;
  localparam int          CC_DIR      = 8;
  localparam int          CC_ON       = 7;
  localparam int          CC_EVOFF    = 6;
  localparam int          CC_CHAIN    = 5;
  localparam int          CC_AUTO     = 4;
  localparam int          CC_SEEN     = 2;
  localparam int          CC_PRI      = 0;
  localparam int          SU_EN       = 7;
  localparam int          SU_TYPE     = 5;
  localparam int          SU_LEN      = 8;
  localparam int          IRQ_W       = 3;
  localparam int          IRQ_BLOCK   = 0;
  localparam int          IRQ_EVENT   = 1;
  localparam int          IRQ_CHAIN   = 2;
  localparam logic [31:0] CRC_RST     = 32'h0000_0000;
  localparam logic [31:0] TAPS_RST    = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic {
    DCC_LFSR  = 1'b0,
    DCC_IPSUM = 1'b1
  } dcc_mode_t;

  typedef struct packed {
    logic       chain_direction;
    logic       channel_on;
    logic       events_when_off;
    logic       chain_allow;
    logic       auto_reenable;
    logic       event_seen;
    logic [1:0] priority_level;
  } dcc_ctrl_t;

  typedef struct packed {
    logic       crc_on;
    dcc_mode_t  checksum_type_select;
    logic [4:0] polynomial_length_field;
  } dcc_setup_t;

  typedef struct packed {
    logic start;
    logic abort;
    logic block_done;
    logic lower_done;
    logic higher_done;
  } dcc_evt_t;

  localparam dcc_ctrl_t  CTRL_RST  = '0;
  localparam dcc_setup_t SETUP_RST = '0;
endpackage

//--- design/dcc_top.sv
// Purpose: CRC seed/result and tap registers plus one DMA channel control register
// Assumes: Channel engine reports events and its transaction activity synchronously
// Notes:   CRC consumes one 16-bit word per valid cycle, MSB first in LFSR mode
//
// How it works
// [R1] Writing CRC value seeds the generator
// [R2] CRC read masks bits above polynomial length
// [R3] Checksum mode upper sixteen bits read zero
// [R4] Checksum mode stores and returns ones' complement
// [R5] Each set tap bit enables feedback XOR
// [R6] Taps ignored in checksum mode
// [R7] Busy reads one while active or enabled
// [R8] Direction picks which neighbour completion enables
// [R9] Enable bit gates channel transfers
// [R10] Disabled channel registers events only if allowed
// [R11] Chaining enables channel only when allowed
// [R12] Without auto-enable, block completion clears enable
// [R13] Event seen flag set on detected event
// [R14] Two-bit priority, three is highest
// [R15] Busy stays until current transaction finishes
// [R16] Unused control bits read zero, ignore writes
// [R17] Type select picks checksum or LFSR
// [R18] Length field holds polynomial length minus one
`timescale 1ns/1ps
module dcc_top #(
  parameter int CRC_IN_W = 16
) (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic [dcc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [dcc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire dcc_pkg::dcc_evt_t         evt,
  input  wire logic                      txn_active,
  input  wire logic                      crc_in_valid,
  input  wire logic [CRC_IN_W-1:0]       crc_in_data,
  output logic                           chan_on,
  output logic [1:0]                     chan_priority,
  output logic                           chan_busy,
  output logic                           irq
);

  function automatic logic [31:0] len_mask(input logic [4:0] len);
    logic [31:0] m;
    m = '0;
    for (int j = 0; j < 32; j++) begin
      m[j] = (j <= int'(len));
    end
    return m;
  endfunction

  function automatic logic [31:0] lfsr_step(input logic [31:0] crc, input logic [31:0] taps,
                                            input logic [4:0] len, input logic [CRC_IN_W-1:0] d);
    logic [31:0] c;
    logic        fb;
    c = crc;
    for (int i = CRC_IN_W - 1; i >= 0; i--) begin
      fb = c[len] ^ d[i];
      c  = {c[30:0], 1'b0} ^ (fb ? taps : 32'h0000_0000);
    end
    return c & len_mask(len);
  endfunction

  function automatic logic [15:0] ip_add(input logic [15:0] s, input logic [15:0] d);
    logic [16:0] t;
    t = {1'b0, s} + {1'b0, d};
    return t[15:0] + {15'h0000, t[16]};
  endfunction

  // Bus state
  logic                       aw_full_ff, nxt_aw_full, w_full_ff, nxt_w_full;
  logic [dcc_pkg::ADDR_W-1:0] aw_addr_ff, nxt_aw_addr, rd_addr_ff, nxt_rd_addr;
  logic [31:0]                w_data_ff, nxt_w_data, rdata_ff, nxt_rdata;
  logic [3:0]                 w_strb_ff, nxt_w_strb;
  logic                       awready_ff, nxt_awready, wready_ff, nxt_wready;
  logic                       bvalid_ff, nxt_bvalid, arready_ff, nxt_arready;
  logic                       rvalid_ff, nxt_rvalid;
  logic [1:0]                 bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic                       do_wr, do_rd;
  logic [31:0]                bmask, rd_val;
  logic                       rd_hit;
  // Block state
  dcc_pkg::dcc_ctrl_t         ctrl_ff, nxt_ctrl;
  dcc_pkg::dcc_setup_t        setup_ff, nxt_setup;
  logic [31:0]                crc_ff, nxt_crc, taps_ff, nxt_taps, crc_view, seed_in;
  logic                       busy_ff, nxt_busy, irq_ff, nxt_irq;
  logic [dcc_pkg::IRQ_W-1:0]  stat_ff, nxt_stat, ien_ff, nxt_ien, ev_set;
  logic                       wr_seed, wr_ctrl, ev_ok, chain_go;

  assign bmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}}, {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  assign do_wr = aw_full_ff && w_full_ff && !bvalid_ff;
  assign do_rd = s_axi_arvalid && arready_ff;

  // Readback view of the CRC state
  always_comb begin
    if (setup_ff.checksum_type_select == dcc_pkg::DCC_IPSUM) begin
      crc_view = {16'h0000, ~crc_ff[15:0]}; // [R3] [R4] [R17]
    end else begin
      crc_view = crc_ff & len_mask(setup_ff.polynomial_length_field); // [R2] [R18]
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (s_axi_araddr)
      dcc_pkg::OFS_SETUP: begin
        rd_val[dcc_pkg::SU_EN]                  = setup_ff.crc_on;
        rd_val[dcc_pkg::SU_TYPE]                = setup_ff.checksum_type_select;
        rd_val[dcc_pkg::SU_LEN +: 5]            = setup_ff.polynomial_length_field;
      end
      dcc_pkg::OFS_SEED:  rd_val = crc_view;
      dcc_pkg::OFS_TAPS:  rd_val = taps_ff;
      dcc_pkg::OFS_CTRL: begin
        // Unlisted bits stay zero
        rd_val[dcc_pkg::CC_BUSY]   = busy_ff; // [R16]
        rd_val[dcc_pkg::CC_DIR]    = ctrl_ff.chain_direction;
        rd_val[dcc_pkg::CC_ON]     = ctrl_ff.channel_on;
        rd_val[dcc_pkg::CC_EVOFF]  = ctrl_ff.events_when_off;
        rd_val[dcc_pkg::CC_CHAIN]  = ctrl_ff.chain_allow;
        rd_val[dcc_pkg::CC_AUTO]   = ctrl_ff.auto_reenable;
        rd_val[dcc_pkg::CC_SEEN]   = ctrl_ff.event_seen;
        rd_val[dcc_pkg::CC_PRI +: 2] = ctrl_ff.priority_level;
      end
      dcc_pkg::OFS_ISTAT: rd_val[dcc_pkg::IRQ_W-1:0] = stat_ff;
      dcc_pkg::OFS_ICLR:  rd_val = 32'h0000_0000;
      dcc_pkg::OFS_IEN:   rd_val[dcc_pkg::IRQ_W-1:0] = ien_ff;
      default:            rd_hit = 1'b0;
    endcase
  end

  // AXI4-Lite handshakes
  always_comb begin
    nxt_aw_full = aw_full_ff;
    nxt_w_full  = w_full_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_data  = w_data_ff;
    nxt_w_strb  = w_strb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rresp   = rresp_ff;
    nxt_rdata   = rdata_ff;
    nxt_rd_addr = rd_addr_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw_full = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_w_full = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (do_wr) begin
      nxt_aw_full = 1'b0;
      nxt_w_full  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = (aw_addr_ff <= dcc_pkg::OFS_IEN && aw_addr_ff[1:0] == 2'h0) ?
                    dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (do_rd) begin
      nxt_rvalid  = 1'b1;
      nxt_rdata   = rd_val;
      nxt_rresp   = rd_hit ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
      nxt_rd_addr = s_axi_araddr;
    end
    // Ready low while a slot is held, so payloads never get overwritten
    nxt_awready = !nxt_aw_full && !nxt_bvalid;
    nxt_wready  = !nxt_w_full && !nxt_bvalid;
    nxt_arready = !nxt_rvalid;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_full_ff <= 1'b0;
      w_full_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= dcc_pkg::RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= dcc_pkg::RESP_OKAY;
      rdata_ff   <= 32'h0000_0000;
      rd_addr_ff <= '0;
    end else begin
      aw_full_ff <= nxt_aw_full;
      w_full_ff  <= nxt_w_full;
      aw_addr_ff <= nxt_aw_addr;
      w_data_ff  <= nxt_w_data;
      w_strb_ff  <= nxt_w_strb;
      awready_ff <= nxt_awready;
      wready_ff  <= nxt_wready;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff  <= nxt_rvalid;
      rresp_ff   <= nxt_rresp;
      rdata_ff   <= nxt_rdata;
      rd_addr_ff <= nxt_rd_addr;
    end
  end

  assign wr_seed  = do_wr && aw_addr_ff == dcc_pkg::OFS_SEED;
  assign wr_ctrl  = do_wr && aw_addr_ff == dcc_pkg::OFS_CTRL;
  assign seed_in  = (crc_view & ~bmask) | (w_data_ff & bmask);
  assign ev_ok    = ctrl_ff.channel_on || ctrl_ff.events_when_off; // [R10]
  // [R8] [R11]
  assign chain_go = ctrl_ff.chain_allow &&
                    (ctrl_ff.chain_direction ? evt.lower_done : evt.higher_done);

  // Register file, CRC engine and channel state
  always_comb begin
    nxt_setup = setup_ff;
    nxt_taps  = taps_ff;
    nxt_crc   = crc_ff;
    nxt_ctrl  = ctrl_ff;
    nxt_ien   = ien_ff;
    ev_set    = '0;
    if (do_wr && aw_addr_ff == dcc_pkg::OFS_SETUP) begin
      if (w_strb_ff[0]) begin
        nxt_setup.crc_on               = w_data_ff[dcc_pkg::SU_EN];
        nxt_setup.checksum_type_select = dcc_pkg::dcc_mode_t'(w_data_ff[dcc_pkg::SU_TYPE]);
      end
      if (w_strb_ff[1]) begin
        nxt_setup.polynomial_length_field = w_data_ff[dcc_pkg::SU_LEN +: 5];
      end
    end
    if (do_wr && aw_addr_ff == dcc_pkg::OFS_TAPS) begin
      nxt_taps = (taps_ff & ~bmask) | (w_data_ff & bmask);
    end
    if (do_wr && aw_addr_ff == dcc_pkg::OFS_IEN) begin
      nxt_ien = w_data_ff[dcc_pkg::IRQ_W-1:0];
    end
    // A seed write outranks data arriving in the same cycle
    if (wr_seed) begin
      if (setup_ff.checksum_type_select == dcc_pkg::DCC_IPSUM) begin
        nxt_crc = {16'h0000, ~seed_in[15:0]}; // [R1] [R4]
      end else begin
        nxt_crc = seed_in; // [R1]
      end
    end else if (crc_in_valid && setup_ff.crc_on) begin
      if (setup_ff.checksum_type_select == dcc_pkg::DCC_IPSUM) begin
        nxt_crc = {16'h0000, ip_add(crc_ff[15:0], crc_in_data[15:0])}; // [R6] [R17]
      end else begin
        nxt_crc = lfsr_step(crc_ff, taps_ff, setup_ff.polynomial_length_field,
                            crc_in_data); // [R5] [R18]
      end
    end
    if (wr_ctrl) begin
      if (w_strb_ff[0]) begin
        nxt_ctrl.channel_on      = w_data_ff[dcc_pkg::CC_ON]; // [R9]
        nxt_ctrl.events_when_off = w_data_ff[dcc_pkg::CC_EVOFF];
        nxt_ctrl.chain_allow     = w_data_ff[dcc_pkg::CC_CHAIN];
        nxt_ctrl.auto_reenable   = w_data_ff[dcc_pkg::CC_AUTO];
        nxt_ctrl.priority_level  = w_data_ff[dcc_pkg::CC_PRI +: 2]; // [R14]
      end
      if (w_strb_ff[1]) begin
        nxt_ctrl.chain_direction = w_data_ff[dcc_pkg::CC_DIR];
      end
    end
    if (evt.block_done) begin
      ev_set[dcc_pkg::IRQ_BLOCK] = 1'b1;
      nxt_ctrl.event_seen = 1'b0;
      if (!ctrl_ff.auto_reenable) begin
        nxt_ctrl.channel_on = 1'b0; // [R12]
      end
    end
    // Hardware set wins over any clear in the same cycle
    if ((evt.start || evt.abort) && ev_ok) begin
      nxt_ctrl.event_seen = 1'b1; // [R10] [R13]
      ev_set[dcc_pkg::IRQ_EVENT] = 1'b1;
    end
    if (chain_go) begin
      nxt_ctrl.channel_on = 1'b1; // [R8] [R11]
      ev_set[dcc_pkg::IRQ_CHAIN] = 1'b1;
    end
    // Busy lingers while the engine finishes the transaction in flight
    nxt_busy = nxt_ctrl.channel_on || txn_active; // [R7] [R15]
    nxt_stat = stat_ff;
    if (do_wr && aw_addr_ff == dcc_pkg::OFS_ICLR) begin
      nxt_stat = stat_ff & ~w_data_ff[dcc_pkg::IRQ_W-1:0];
    end
    nxt_stat = nxt_stat | ev_set;
    nxt_irq  = |(nxt_stat & nxt_ien);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      setup_ff <= dcc_pkg::SETUP_RST;
      taps_ff  <= dcc_pkg::TAPS_RST;
      crc_ff   <= dcc_pkg::CRC_RST;
      ctrl_ff  <= dcc_pkg::CTRL_RST;
      ien_ff   <= '0;
      stat_ff  <= '0;
      busy_ff  <= 1'b0;
      irq_ff   <= 1'b0;
    end else begin
      setup_ff <= nxt_setup;
      taps_ff  <= nxt_taps;
      crc_ff   <= nxt_crc;
      ctrl_ff  <= nxt_ctrl;
      ien_ff   <= nxt_ien;
      stat_ff  <= nxt_stat;
      busy_ff  <= nxt_busy;
      irq_ff   <= nxt_irq;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign chan_on       = ctrl_ff.channel_on;
  assign chan_priority = ctrl_ff.priority_level;
  assign chan_busy     = busy_ff;
  assign irq           = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic lfsr_md;
  assign lfsr_md = setup_ff.checksum_type_select == dcc_pkg::DCC_LFSR;

  seed_load_a: assert property (wr_seed && lfsr_md && w_strb_ff == 4'hf |=> // [R1]
    crc_ff == $past(w_data_ff)) else $error("seed not loaded");
  len_mask_a: assert property ($rose(rvalid_ff) && rd_addr_ff == dcc_pkg::OFS_SEED && // [R2]
    lfsr_md |-> (rdata_ff & ~len_mask(setup_ff.polynomial_length_field)) == 32'h0)
    else $error("crc bits above length nonzero");
  ip_upper_a: assert property ($rose(rvalid_ff) && rd_addr_ff == dcc_pkg::OFS_SEED && // [R3]
    !lfsr_md |-> rdata_ff[31:16] == 16'h0000) else $error("checksum upper half nonzero");
  ip_comp_a: assert property (wr_seed && !lfsr_md && w_strb_ff == 4'hf ##1 // [R4]
    !wr_seed && !crc_in_valid && !lfsr_md |-> crc_view[15:0] == $past(w_data_ff[15:0]))
    else $error("checksum readback wrong");
  tap_zero_a: assert property (crc_in_valid && setup_ff.crc_on && lfsr_md && // [R5]
    !wr_seed && taps_ff == 32'h0 |=> crc_ff[15:0] == 16'h0000) else $error("no-tap shift wrong");
  ip_sum_a: assert property (crc_in_valid && setup_ff.crc_on && !lfsr_md && !wr_seed |=> // [R6]
    crc_ff[15:0] == ip_add($past(crc_ff[15:0]), $past(crc_in_data[15:0])))
    else $error("checksum sum wrong");
  // Busy is registered from next enable, so it tracks enable now and activity a cycle back
  busy_on_a: assert property (chan_on || $past(txn_active) |-> chan_busy) // [R7]
    else $error("busy missing");
  busy_off_a: assert property (!chan_on && !txn_active && !wr_ctrl && !chain_go |=> // [R15]
    !chan_busy) else $error("busy stuck");
  chain_en_a: assert property (chain_go |=> chan_on && stat_ff[dcc_pkg::IRQ_CHAIN]) // [R8]
    else $error("chain enable missed");
  no_chain_a: assert property (!chan_on && !ctrl_ff.chain_allow && !wr_ctrl |=> // [R11]
    !chan_on) else $error("enabled without chaining");
  auto_off_a: assert property (evt.block_done && !ctrl_ff.auto_reenable && !chain_go |=> // [R12]
    !chan_on) else $error("enable not cleared");
  ev_ignore_a: assert property (!chan_on && !ctrl_ff.events_when_off && // [R10]
    !ctrl_ff.event_seen && !chain_go |=> !ctrl_ff.event_seen) else $error("event taken off");
  ev_seen_a: assert property ((evt.start || evt.abort) && ev_ok |=> // [R13]
    ctrl_ff.event_seen && stat_ff[dcc_pkg::IRQ_EVENT]) else $error("event lost");
  ctrl_zero_a: assert property ($rose(rvalid_ff) && rd_addr_ff == dcc_pkg::OFS_CTRL |-> // [R16]
    rdata_ff[31:16] == 16'h0000 && rdata_ff[14:9] == 6'h00) else $error("reserved bits set");
  pri_out_a: assert property (wr_ctrl && w_strb_ff[0] |=> // [R14]
    chan_priority == $past(w_data_ff[1:0])) else $error("priority not applied");
  on_out_a: assert property (wr_ctrl && w_strb_ff[0] && !evt.block_done && !chain_go |=> // [R9]
    chan_on == $past(w_data_ff[dcc_pkg::CC_ON])) else $error("enable not applied");

  rd_seed_c: cover property (do_rd && s_axi_araddr == dcc_pkg::OFS_SEED ##1 rvalid_ff);
  chain_c:   cover property (chain_go ##1 chan_on);
  drain_c:   cover property (!chan_on && txn_active ##1 chan_busy ##1 !chan_busy);
  irq_c:     cover property ($rose(irq));
endmodule

//--- dv/dcc_engine_model.sv
// Purpose: Channel engine stand-in feeding the CRC path and reporting transactions
// Assumes: One word per request, transaction lasts hold cycles
// Notes:   Idle data bus toggles so a stale word is never mistaken for fresh
`timescale 1ns/1ps
module dcc_engine_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        chan_on,
  input  wire logic        req,
  input  wire logic [15:0] word,
  input  wire logic [3:0]  hold,
  output logic             txn_active,
  output logic             crc_in_valid,
  output logic [15:0]      crc_in_data
);
  logic [3:0] cnt_ff;

  assign txn_active = (cnt_ff != 4'h0);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff       <= 4'h0;
      crc_in_valid <= 1'b0;
      crc_in_data  <= 16'h0000;
    end else begin
      crc_in_valid <= 1'b0;
      crc_in_data  <= ~crc_in_data;
      if (cnt_ff != 4'h0) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
      // Disabled channel moves no data
      if (req && chan_on && !txn_active) begin
        crc_in_valid <= 1'b1;
        crc_in_data  <= word;
        cnt_ff       <= hold;
      end
    end
  end
endmodule

//--- dv/tb_dcc_top.sv
// Purpose: Self-checking bench for the CRC and channel control block
// Assumes: Engine model stands at the far side, bench drives events and bus
// Notes:   Expected CRC values come from bench functions
`timescale 1ns/1ps
module tb_dcc_top;
  logic              clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, req;
  logic [7:0]        awaddr, araddr;
  logic [31:0]       wdata, rdata, sd, tp, ex;
  logic [3:0]        wstrb, hold;
  logic [15:0]       word, crc_d, w16, s16;
  logic [4:0]        ln;
  dcc_pkg::dcc_evt_t evt;
  logic              awready, wready, bvalid, arready, rvalid, txn_active, crc_v;
  logic              chan_on, chan_busy, irq;
  logic [1:0]        bresp, rresp, prio;
  int                n_errors = 0, cmp_count = 0, cyc = 0;

  dcc_top i_dcc_top (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .evt(evt), .txn_active(txn_active), .crc_in_valid(crc_v),
    .crc_in_data(crc_d), .chan_on(chan_on), .chan_priority(prio), .chan_busy(chan_busy),
    .irq(irq));
  dcc_engine_model i_dcc_engine_model (.clk(clk), .sys_rst(sys_rst), .chan_on(chan_on),
    .req(req), .word(word), .hold(hold), .txn_active(txn_active), .crc_in_valid(crc_v),
    .crc_in_data(crc_d));

  always #25 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      end_sim();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] c, input logic [31:0] t,
                                       input logic [4:0] n, input logic [15:0] d);
    logic fb;
    for (int i = 15; i >= 0; i--) begin
      fb = c[n] ^ d[i];
      c = (c << 1) ^ (fb ? t : 32'h0000_0000);
    end
    return c & (32'hffff_ffff >> (5'h1f - n));
  endfunction

  function automatic logic [15:0] ipadd(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count = cmp_count + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = dcc_pkg::RESP_OKAY);
    bit aw;
    bit wd;
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    {awvalid, wvalid, bready} <= 3'h7;
    aw = 1'b0;
    wd = 1'b0;
    while (!(aw && wd)) begin
      @(posedge clk);
      if (awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, bresp});
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm,
                      input logic [1:0] er = dcc_pkg::RESP_OKAY);
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(nm, e, rdata);
    chk("read response", {30'h0, er}, {30'h0, rresp});
  endtask

  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    evt <= dcc_pkg::dcc_evt_t'(v);
    @(posedge clk);
    evt <= '0;
    repeat (3) @(posedge clk);
  endtask

  task automatic send(input logic [15:0] v, input logic [3:0] h);
    @(posedge clk);
    {req, word, hold} <= {1'b1, v, h};
    @(posedge clk);
    req <= 1'b0;
    repeat (h + 2) @(posedge clk);
  endtask

  initial begin
    {clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, req} = 8'h40;
    {awaddr, araddr, wdata, wstrb, hold, word} = '0;
    evt = '0;
    void'($urandom(32'hd222));
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 7; a++) rchk(8'(a * 4), 32'h0000_0000, "reset value");
    rchk(8'h1c, 32'h0000_0000, "unmapped read", dcc_pkg::RESP_SLVERR);
    wr(8'h20, $urandom, dcc_pkg::RESP_SLVERR);
    for (int p = 0; p < 4; p++) begin
      sd = ($urandom & 32'hffff_fffc) | 32'(p);
      wr(dcc_pkg::OFS_CTRL, sd);
      rchk(dcc_pkg::OFS_CTRL, (sd & 32'h0000_01f3) | {16'h0, sd[7], 15'h0},
           "control");
      chk("priority", 32'(p), {30'h0, prio});
      chk("enable", {31'h0, sd[7]}, {31'h0, chan_on});
    end
    for (int k = 0; k < 8; k++) begin
      wr(dcc_pkg::OFS_CTRL, {23'h0, k[1], 2'h0, k[2], 5'h00});
      pulse(k[0] ? 5'h02 : 5'h01);
      chk("chain", {31'h0, k[2] & (k[1] == k[0])}, {31'h0, chan_on});
    end
    for (int a = 0; a < 2; a++) begin
      wr(dcc_pkg::OFS_CTRL, 32'h0000_0080 | 32'(a << 4));
      pulse(5'h04);
      chk("auto enable", {31'h0, a[0]}, {31'h0, chan_on});
    end
    for (int k = 0; k < 8; k++) begin
      wr(dcc_pkg::OFS_CTRL, {24'h0, k[1], k[0], 6'h00});
      pulse(k[2] ? 5'h10 : 5'h08);
      rchk(dcc_pkg::OFS_CTRL, {16'h0, k[1], 7'h0, k[1], k[0], 3'h0, k[1] | k[0], 2'h0},
           "event seen");
      pulse(5'h04);
    end
    // Auto-enable on so completions never stop the CRC feed
    wr(dcc_pkg::OFS_CTRL, 32'h0000_0090);
    for (int i = 0; i < 9; i++) begin
      ln = (i == 0) ? 5'h1f : (i == 1) ? 5'h00 : 5'($urandom);
      sd = $urandom;
      // Zero taps once, so the plain-shift case is reached
      tp = (i == 2) ? 32'h0000_0000 : $urandom;
      wr(dcc_pkg::OFS_SETUP, {19'h0, ln, (i > 5) ? 8'ha0 : 8'h80});
      wr(dcc_pkg::OFS_TAPS, tp);
      rchk(dcc_pkg::OFS_TAPS, tp, "taps");
      wr(dcc_pkg::OFS_SEED, sd);
      ex = (i > 5) ? {16'h0, sd[15:0]} : sd & (32'hffff_ffff >> (5'h1f - ln));
      rchk(dcc_pkg::OFS_SEED, ex, "crc seed");
      s16 = ~sd[15:0];
      for (int j = 0; j < 3; j++) begin
        w16 = 16'($urandom);
        ex = lfsr(ex, tp, ln, w16);
        s16 = ipadd(s16, w16);
        send(w16, 4'h1);
      end
      ex = (i > 5) ? {16'h0, ~s16} : ex;
      rchk(dcc_pkg::OFS_SEED, ex, "crc result");
    end
    wr(dcc_pkg::OFS_CTRL, 32'h0000_0080);
    send(16'h1234, 4'h1);
    @(posedge clk);
    {req, word, hold} <= {1'b1, 16'hbeef, 4'ha};
    @(posedge clk);
    req <= 1'b0;
    wr(dcc_pkg::OFS_CTRL, 32'h0000_0000);
    chk("enable off", 32'h0, {31'h0, chan_on});
    chk("busy draining", 32'h1, {31'h0, chan_busy});
    repeat (12) @(posedge clk);
    rchk(dcc_pkg::OFS_CTRL, 32'h0000_0000, "busy idle");
    wr(dcc_pkg::OFS_ICLR, 32'h0000_0007);
    wr(dcc_pkg::OFS_IEN, 32'h0000_0001);
    pulse(5'h04);
    chk("irq raised", 32'h1, {31'h0, irq});
    rchk(dcc_pkg::OFS_ISTAT, 32'h0000_0001, "irq status");
    rchk(dcc_pkg::OFS_ICLR, 32'h0000_0000, "irq clear view");
    wr(dcc_pkg::OFS_ICLR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(dcc_pkg::OFS_IEN, 32'h0000_0000);
    pulse(5'h04);
    chk("irq masked", 32'h0, {31'h0, irq});
    rchk(dcc_pkg::OFS_ISTAT, 32'h0000_0001, "irq sticky");
    end_sim();
  end
endmodule
